/* rtl/qdac_i2c_rx.sv */
// Two-wire write receiver of a quad 10-bit converter with Wishbone access
//
// Notes on behaviour
// - Answer the 7-bit address 10011 plus two address pins, in all speeds.
// - Control byte: extension bits, load mode, spare, channel, power-down flag.
// - Power-down flag picks conversion data or power-down data afterwards.
// - Flag clear: high/low data pairs repeat until STOP or repeated START.
// - Flag set: exactly two power-down bytes are taken, then nothing more.
// - High byte holds bits 9..2, low byte top bits hold bits 1..0.
// - Master code 0000 1xxx is never acknowledged; then repeated START.
// - Update happens at the falling clock ending the low byte acknowledge.
// - With flag set, top two high-byte bits are the power-down mode.
`timescale 1ns/100ps
`default_nettype none
module qdac_i2c_rx (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        link_clk_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        addr_pin_hi_i,
   input  wire logic        addr_pin_lo_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::WORD_W-1:0] dac_word_o
);
   // Link domain reset and input synchronisers
   logic       lr1_q, lrst_q;
   logic       scl1_q, scl2_q, scl3_q;
   logic       sda1_q, sda2_q, sda3_q;
   logic [1:0] ap1_q, ap2_q;
   logic       en1_q, en2_q;
   logic [2:0] ctrl_q, ctrl_d;

   always_ff @(posedge link_clk_i) begin
      lr1_q  <= rst_i;
      lrst_q <= lr1_q;
      scl1_q <= scl_i;
      scl2_q <= scl1_q;
      scl3_q <= scl2_q;
      sda1_q <= sda_i;
      sda2_q <= sda1_q;
      sda3_q <= sda2_q;
      ap1_q  <= {addr_pin_hi_i, addr_pin_lo_i};
      ap2_q  <= ap1_q;
      en1_q  <= ctrl_q[qdac_pkg::CR_EN];
      en2_q  <= en1_q;
   end

   logic start_c, stop_c, rise_c, fall_c, match_c;
   assign start_c = scl2_q & scl3_q & sda3_q & ~sda2_q;
   assign stop_c  = scl2_q & scl3_q & ~sda3_q & sda2_q;
   assign rise_c  = scl2_q & ~scl3_q;
   assign fall_c  = ~scl2_q & scl3_q;

   // Link protocol engine
   qdac_pkg::qdac_link_e st_q, st_d;
   logic [qdac_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ctrlb_q, ctrlb_d, hi_q, hi_d;
   logic       ack_q, ack_d, oe_d, sda_d, hl_q, hl_d;
   logic       pend_q, pend_d, evt_q, evt_d, hs_q, hs_d;
   qdac_pkg::qdac_upd_s upd_q, upd_d;
   assign match_c = (sh_q == {qdac_pkg::ADDR_PREFIX, ap2_q, 1'h0});

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ack_d   = ack_q;
      oe_d    = sda_oe_o;
      sda_d   = 1'h0;
      hl_d    = hl_q;
      pend_d  = pend_q;
      evt_d   = 1'h0;
      ctrlb_d = ctrlb_q;
      hi_d    = hi_q;
      upd_d   = upd_q;
      hs_d    = hs_q;
      if (start_c) begin
         // Repeated START also ends a data run
         st_d   = en2_q ? qdac_pkg::ST_ADDR : qdac_pkg::ST_IDLE;
         cnt_d  = '0;
         ack_d  = 1'h0;
         oe_d   = 1'h0;
         hl_d   = 1'h0;
         pend_d = 1'h0;
      end else if (stop_c) begin
         st_d   = qdac_pkg::ST_IDLE;
         ack_d  = 1'h0;
         oe_d   = 1'h0;
         pend_d = 1'h0;
         hs_d   = 1'h0;
      end else if (st_q != qdac_pkg::ST_IDLE) begin
         if (rise_c && !ack_q) begin
            sh_d  = {sh_q[6:0], sda2_q};
            cnt_d = cnt_q + 4'h1;
         end
         if (fall_c && ack_q) begin
            ack_d  = 1'h0;
            oe_d   = 1'h0;
            cnt_d  = '0;
            evt_d  = pend_q;
            pend_d = 1'h0;
         end else if (fall_c && cnt_q == qdac_pkg::BYTE_END) begin
            case (st_q)
               qdac_pkg::ST_ADDR: begin
                  if (match_c) begin
                     ack_d = 1'h1;
                     oe_d  = 1'h1;
                     st_d  = qdac_pkg::ST_CTRL;
                  end else begin
                     // Master code and foreign addresses stay unanswered
                     st_d = qdac_pkg::ST_DONE;
                     if (sh_q[7:3] == qdac_pkg::HS_PREFIX) begin
                        hs_d = 1'h1;
                     end
                  end
               end
               qdac_pkg::ST_CTRL: begin
                  ack_d   = 1'h1;
                  oe_d    = 1'h1;
                  ctrlb_d = sh_q;
                  hl_d    = 1'h0;
                  st_d    = sh_q[qdac_pkg::CB_PD] ? qdac_pkg::ST_PD
                                                  : qdac_pkg::ST_DATA;
               end
               qdac_pkg::ST_DATA, qdac_pkg::ST_PD: begin
                  ack_d = 1'h1;
                  oe_d  = 1'h1;
                  if (!hl_q) begin
                     hi_d = sh_q;
                     hl_d = 1'h1;
                  end else begin
                     upd_d  = '{ctrl: ctrlb_q, hi: hi_q, lo: sh_q};
                     pend_d = 1'h1;
                     hl_d   = 1'h0;
                     if (st_q == qdac_pkg::ST_PD) begin
                        st_d = qdac_pkg::ST_DONE;
                     end
                  end
               end
               default: begin
                  st_d = st_q;
               end
            endcase
         end
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst_q) begin
         st_q     <= qdac_pkg::ST_IDLE;
         cnt_q    <= '0;
         sh_q     <= 8'h00;
         ack_q    <= 1'h0;
         sda_oe_o <= 1'h0;
         sda_o    <= 1'h0;
         hl_q     <= 1'h0;
         pend_q   <= 1'h0;
         evt_q    <= 1'h0;
         ctrlb_q  <= 8'h00;
         hi_q     <= 8'h00;
         upd_q    <= '0;
         hs_q     <= 1'h0;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         sh_q     <= sh_d;
         ack_q    <= ack_d;
         sda_oe_o <= oe_d;
         sda_o    <= sda_d;
         hl_q     <= hl_d;
         pend_q   <= pend_d;
         evt_q    <= evt_d;
         ctrlb_q  <= ctrlb_d;
         hi_q     <= hi_d;
         upd_q    <= upd_d;
         hs_q     <= hs_d;
      end
   end

   property p_addr_ack;
      @(posedge link_clk_i) disable iff (lrst_q)
      (fall_c && !ack_q && cnt_q == 4'h8 && st_q == qdac_pkg::ST_ADDR &&
       sh_q == {5'h13, ap2_q, 1'h0}) |=> (sda_oe_o && st_q == qdac_pkg::ST_CTRL);
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");

   property p_foreign;
      @(posedge link_clk_i) disable iff (lrst_q)
      (fall_c && !ack_q && cnt_q == 4'h8 && st_q == qdac_pkg::ST_ADDR &&
       !match_c) |=> (!sda_oe_o && st_q == qdac_pkg::ST_DONE);
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("foreign address was answered");

   property p_master_code;
      @(posedge link_clk_i) disable iff (lrst_q)
      (fall_c && !ack_q && cnt_q == 4'h8 && st_q == qdac_pkg::ST_ADDR &&
       sh_q[7:3] == 5'h01) |=> (hs_q && !sda_oe_o) [*2];
   endproperty
   a_master_code: assert property (p_master_code)
      else $error("master code acknowledged or not noted");

   property p_ctrl_route;
      @(posedge link_clk_i) disable iff (lrst_q)
      (fall_c && !ack_q && cnt_q == 4'h8 && st_q == qdac_pkg::ST_CTRL)
      |=> st_q == ($past(sh_q[0]) ? qdac_pkg::ST_PD : qdac_pkg::ST_DATA);
   endproperty
   a_ctrl_route: assert property (p_ctrl_route)
      else $error("control byte flag routed wrongly");

   property p_pd_two;
      @(posedge link_clk_i) disable iff (lrst_q)
      (fall_c && !ack_q && cnt_q == 4'h8 && st_q == qdac_pkg::ST_PD && hl_q)
      |=> (st_q == qdac_pkg::ST_DONE && pend_q);
   endproperty
   a_pd_two: assert property (p_pd_two)
      else $error("power-down run not closed after two bytes");

   property p_evt_at_ack;
      @(posedge link_clk_i) disable iff (lrst_q)
      evt_q |-> ($past(fall_c) && $past(ack_q) && !sda_oe_o);
   endproperty
   a_evt_at_ack: assert property (p_evt_at_ack)
      else $error("update outside the acknowledge falling edge");

   property p_bus_cond;
      @(posedge link_clk_i) disable iff (lrst_q)
      (start_c || stop_c) |=> (!sda_oe_o && !pend_q && !ack_q);
   endproperty
   a_bus_cond: assert property (p_bus_cond)
      else $error("bus condition did not end the run");

   // Event crossing to the system domain
   logic                        uvld_c;
   logic [$bits(qdac_pkg::qdac_upd_s)-1:0] udat_c;
   qdac_pkg::qdac_upd_s         u_c;

   qdac_xfer #(
      .W ($bits(qdac_pkg::qdac_upd_s))
   ) u_xfer (
      .src_clk_i  (link_clk_i),
      .src_rst_i  (lrst_q),
      .src_vld_i  (evt_q),
      .src_data_i (upd_q),
      .dst_clk_i  (clk_i),
      .dst_rst_i  (rst_i),
      .dst_vld_o  (uvld_c),
      .dst_data_o (udat_c)
   );
   assign u_c = qdac_pkg::qdac_upd_s'(udat_c);

   // Converter register update
   logic [1:0]  ch_c, lm_c;
   logic        pd_c, hit_c;
   logic [11:0] word_c;
   logic [qdac_pkg::NUM_CH-1:0][11:0] temp_q, temp_d, dac_d;
   logic [15:0] ucnt_q, ucnt_d;
   logic [7:0]  last_q, last_d;
   logic        hs1_q, hs2_q;

   always_comb begin
      ch_c   = u_c.ctrl[qdac_pkg::CB_SEL+:2];
      lm_c   = u_c.ctrl[qdac_pkg::CB_LOAD+:2];
      pd_c   = u_c.ctrl[qdac_pkg::CB_PD];
      hit_c  = (u_c.ctrl[qdac_pkg::CB_EXT+:2] == ctrl_q[qdac_pkg::CR_EXT+:2])
               || (lm_c == qdac_pkg::LM_BCAST);
      word_c = pd_c ? {u_c.hi[7:6], temp_q[ch_c][9:0]}
                    : {2'h0, u_c.hi, u_c.lo[7:6]};
      temp_d = temp_q;
      dac_d  = dac_word_o;
      ucnt_d = ucnt_q;
      last_d = last_q;
      if (uvld_c && hit_c) begin
         temp_d[ch_c] = word_c;
         ucnt_d       = ucnt_q + 16'h1;
         last_d       = u_c.ctrl;
         for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
            if ((lm_c == qdac_pkg::LM_ONE && ch_c == 2'(i)) ||
                lm_c == qdac_pkg::LM_ALL || lm_c == qdac_pkg::LM_BCAST) begin
               dac_d[i] = temp_d[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      hs1_q <= hs_q;
      hs2_q <= hs1_q;
      if (rst_i) begin
         temp_q     <= '0;
         dac_word_o <= '0;
         ucnt_q     <= 16'h0000;
         last_q     <= 8'h00;
      end else begin
         temp_q     <= temp_d;
         dac_word_o <= dac_d;
         ucnt_q     <= ucnt_d;
         last_q     <= last_d;
      end
   end

   property p_data_word;
      @(posedge clk_i) disable iff (rst_i)
      (uvld_c && hit_c && !pd_c) |=>
      temp_q[$past(ch_c)] == {2'h0, $past(u_c.hi), $past(u_c.lo[7:6])};
   endproperty
   a_data_word: assert property (p_data_word)
      else $error("data word assembled wrongly");

   property p_pd_word;
      @(posedge clk_i) disable iff (rst_i)
      (uvld_c && hit_c && pd_c) |=>
      (temp_q[$past(ch_c)][11:10] == $past(u_c.hi[7:6]) &&
       temp_q[$past(ch_c)][9:0] == $past(temp_q[ch_c][9:0]));
   endproperty
   a_pd_word: assert property (p_pd_word)
      else $error("power-down code stored wrongly");

   // Wishbone slave: one wait state, unmapped reads return zero
   logic        req_c, wack_d;
   logic [31:0] rd_d;

   assign req_c = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always_comb begin
      wack_d = req_c;
      ctrl_d = ctrl_q;
      rd_d   = 32'h0000_0000;
      if (req_c && wb_we_i && wb_adr_i == qdac_pkg::OFF_CTRL && wb_sel_i[0]) begin
         ctrl_d = wb_dat_i[2:0];
      end
      if (wb_adr_i == qdac_pkg::OFF_CTRL) begin
         rd_d[2:0] = ctrl_q;
      end else if (wb_adr_i == qdac_pkg::OFF_STAT) begin
         rd_d[qdac_pkg::SR_HS]      = hs2_q;
         rd_d[qdac_pkg::SR_LAST+:8] = last_q;
         rd_d[qdac_pkg::SR_CNT+:16] = ucnt_q;
      end else if (wb_adr_i[7:4] == qdac_pkg::OFF_TEMP[7:4] &&
                   wb_adr_i[1:0] == 2'h0) begin
         rd_d[11:0] = temp_q[wb_adr_i[3:2]];
      end else if (wb_adr_i[7:4] == qdac_pkg::OFF_DAC[7:4] &&
                   wb_adr_i[1:0] == 2'h0) begin
         rd_d[11:0] = dac_word_o[wb_adr_i[3:2]];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q   <= qdac_pkg::CTRL_RST;
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ctrl_q   <= ctrl_d;
         wb_ack_o <= wack_d;
         wb_dat_o <= rd_d;
      end
   end

   property p_wb_ack;
      @(posedge clk_i) disable iff (rst_i)
      req_c |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack)
      else $error("bus answer not a single cycle");
endmodule
`default_nettype wire

/* rtl/qdac_pkg.sv */
// Shared constants and types of the quad converter write receiver
package qdac_pkg;
   localparam int NUM_CH   = 4;
   localparam int WORD_W   = 12;
   localparam int CNT_W    = 4;
   localparam logic [3:0] BYTE_END = 4'h8;

   // Fixed upper bits of the bus address and of the high-speed master code
   localparam logic [4:0] ADDR_PREFIX = 5'h13;
   localparam logic [4:0] HS_PREFIX   = 5'h01;

   // Control byte field positions
   localparam int CB_PD   = 0;
   localparam int CB_SEL  = 1;
   localparam int CB_LOAD = 4;
   localparam int CB_EXT  = 6;

   // Load modes
   localparam logic [1:0] LM_TEMP  = 2'h0;
   localparam logic [1:0] LM_ONE   = 2'h1;
   localparam logic [1:0] LM_ALL   = 2'h2;
   localparam logic [1:0] LM_BCAST = 2'h3;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_TEMP = 8'h10;
   localparam logic [7:0] OFF_DAC  = 8'h20;

   // Control register layout and reset value
   localparam int CR_EN  = 0;
   localparam int CR_EXT = 1;
   localparam logic [2:0] CTRL_RST = 3'h1;

   // Status register layout
   localparam int SR_HS   = 0;
   localparam int SR_LAST = 8;
   localparam int SR_CNT  = 16;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CTRL,
      ST_DATA,
      ST_PD,
      ST_DONE
   } qdac_link_e;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] hi;
      logic [7:0] lo;
   } qdac_upd_s;
endpackage

/* rtl/qdac_xfer.sv */
// Toggle handshake carrying one word from the link domain to the system
`timescale 1ns/100ps
`default_nettype none
module qdac_xfer #(
   parameter int W = 24
) (
   input  wire logic         src_clk_i,
   input  wire logic         src_rst_i,
   input  wire logic         src_vld_i,
   input  wire logic [W-1:0] src_data_i,
   input  wire logic         dst_clk_i,
   input  wire logic         dst_rst_i,
   output logic              dst_vld_o,
   output logic [W-1:0]      dst_data_o
);
   logic         tgl_q, tgl_d;
   logic [W-1:0] hold_q, hold_d;
   logic         s1_q, s2_q, s3_q;
   logic         s1_d, s2_d, s3_d;
   logic         vld_d;
   logic [W-1:0] data_d;

   always_comb begin
      tgl_d  = tgl_q ^ src_vld_i;
      hold_d = src_vld_i ? src_data_i : hold_q;
   end

   always_ff @(posedge src_clk_i) begin
      if (src_rst_i) begin
         tgl_q  <= 1'h0;
         hold_q <= '0;
      end else begin
         tgl_q  <= tgl_d;
         hold_q <= hold_d;
      end
   end

   // Hold word is stable for several cycles before the toggle is seen
   always_comb begin
      s1_d   = tgl_q;
      s2_d   = s1_q;
      s3_d   = s2_q;
      vld_d  = s2_q ^ s3_q;
      data_d = vld_d ? hold_q : dst_data_o;
   end

   always_ff @(posedge dst_clk_i) begin
      if (dst_rst_i) begin
         s1_q       <= 1'h0;
         s2_q       <= 1'h0;
         s3_q       <= 1'h0;
         dst_vld_o  <= 1'h0;
         dst_data_o <= '0;
      end else begin
         s1_q       <= s1_d;
         s2_q       <= s2_d;
         s3_q       <= s3_d;
         dst_vld_o  <= vld_d;
         dst_data_o <= data_d;
      end
   end
endmodule
`default_nettype wire

/* testbench/qdac_i2c_master.sv */
// Two-wire bus master model driving the receiver's link pins
`timescale 1ns/100ps
`default_nettype none
module qdac_i2c_master #(
   parameter int Q = 8
) (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // Bus idles high: clock released, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic qw(input int n);
      repeat (n * Q) @(posedge clk_i);
   endtask

   // Also serves as repeated start from a low clock
   task automatic start();
      sda_low_o <= 1'b0;
      qw(1);
      scl_o <= 1'b1;
      qw(1);
      sda_low_o <= 1'b1;
      qw(1);
      scl_o <= 1'b0;
      qw(1);
   endtask

   task automatic stop();
      sda_low_o <= 1'b1;
      qw(1);
      scl_o <= 1'b1;
      qw(1);
      sda_low_o <= 1'b0;
      qw(2);
   endtask

   // Data moves only while the clock is low
   task automatic bitx(input logic b, output logic s);
      sda_low_o <= ~b;
      qw(1);
      scl_o <= 1'b1;
      qw(1);
      s = sda_i;
      qw(1);
      scl_o <= 1'b0;
      qw(1);
   endtask

   // Ninth bit released, so a zero there is the slave's acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], s);
      bitx(1'b1, ack);
   endtask
endmodule
`default_nettype wire

/* testbench/qdac_i2c_rx_tb_top.sv */
// Self-checking bench of the quad converter write receiver
`timescale 1ns/100ps
`default_nettype none
module qdac_i2c_rx_tb_top;
   localparam logic [7:0] DEV_W = {qdac_pkg::ADDR_PREFIX, 2'b10, 1'b0};
   logic        clk_i = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst_i = 1'b1;
   logic        scl;
   logic        sda_low;
   logic        sda_o;
   logic        sda_oe;
   logic        sda_line;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        ack;
   logic        a;
   logic [7:0]  c;
   logic [qdac_pkg::NUM_CH-1:0][qdac_pkg::WORD_W-1:0] dac_word;
   logic [11:0] tmp_m [4] = '{default: 12'h000};
   logic [11:0] out_m [4] = '{default: 12'h000};
   logic [15:0] upd_cnt = 16'h0;
   logic [7:0]  last_ctrl = 8'h00;
   logic        hs_m = 1'b0;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cycles = 0;

   // Open-drain wire with pull-up
   assign sda_line = !(sda_low || (sda_oe && !sda_o));

   initial forever #10 clk_i = ~clk_i;
   initial begin
      #3.7;
      forever #7.5 link_clk = ~link_clk;
   end

   qdac_i2c_rx qdac_i2c_rx_i (
      .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
      .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .addr_pin_hi_i(1'b1), .addr_pin_lo_i(1'b0),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .dac_word_o(dac_word));

   qdac_i2c_master qdac_i2c_master_i (
      .clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until the edge that samples ack high; data taken there
   task automatic wb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
      logic [31:0] r;
      wb(1'b0, ad, 32'h0, r);
      chk(r, exp);
   endtask

   task automatic tx(input logic [7:0] d, input logic nak);
      qdac_i2c_master_i.wbyte(d, a);
      chk(32'(a), 32'(nak));
   endtask

   // Reference of temporary and output words
   task automatic upd(input logic [7:0] cb, input logic [7:0] h,
                      input logic [7:0] l);
      int ch;
      ch = int'(cb[2:1]);
      if (cb[0])
         tmp_m[ch][11:10] = h[7:6];
      else
         tmp_m[ch] = {2'b00, h, l[7:6]};
      if (cb[5:4] == qdac_pkg::LM_ONE)
         out_m[ch] = tmp_m[ch];
      else if (cb[5:4] != qdac_pkg::LM_TEMP)
         out_m = tmp_m;
      upd_cnt++;
      last_ctrl = cb;
   endtask

   task automatic send(input logic [7:0] cb, input logic [7:0] h,
                       input logic [7:0] l);
      qdac_i2c_master_i.start();
      tx(DEV_W, 1'b0);
      tx(cb, 1'b0);
      tx(h, 1'b0);
      tx(l, 1'b0);
      qdac_i2c_master_i.stop();
      repeat (20) @(posedge clk_i);
   endtask

   task automatic check_all();
      for (int ch = 0; ch < 4; ch++) begin
         chk(32'(dac_word[ch]), 32'(out_m[ch]));
         rd_chk(qdac_pkg::OFF_TEMP + 8'(4 * ch), 32'(tmp_m[ch]));
         rd_chk(qdac_pkg::OFF_DAC + 8'(4 * ch), 32'(out_m[ch]));
      end
      rd_chk(qdac_pkg::OFF_STAT, {upd_cnt, last_ctrl, 7'h00, hs_m});
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rd_chk(qdac_pkg::OFF_CTRL, 32'(qdac_pkg::CTRL_RST));
      wb(1'b1, 8'h08, 32'hffff_ffff, q);
      rd_chk(8'h08, 32'h0);
      check_all();
      $display("test reset done");

      // Back-to-back pairs; low six bits of the low byte ignored
      c = {2'b00, qdac_pkg::LM_ONE, 1'b0, 2'h2, 1'b0};
      qdac_i2c_master_i.start();
      tx(DEV_W, 1'b0);
      tx(c, 1'b0);
      for (int i = 0; i < 2; i++) begin
         tx(8'ha5 + 8'(i), 1'b0);
         tx(i ? 8'h7f : 8'hc0, 1'b0);
         upd(c, 8'ha5 + 8'(i), i ? 8'h7f : 8'hc0);
      end
      qdac_i2c_master_i.stop();
      repeat (20) @(posedge clk_i);
      check_all();
      $display("test data pairs done");

      // Foreign pin address and read direction are ignored
      for (int i = 0; i < 2; i++) begin
         qdac_i2c_master_i.start();
         tx(i ? (DEV_W | 8'h01) : (DEV_W ^ 8'h02), 1'b1);
         qdac_i2c_master_i.stop();
      end
      $display("test foreign address done");

      // Master code, then a power-down run with an extra byte
      qdac_i2c_master_i.start();
      tx(8'h0d, 1'b1);
      hs_m = 1'b1;
      c = {2'b00, qdac_pkg::LM_ONE, 1'b0, 2'h1, 1'b1};
      qdac_i2c_master_i.start();
      tx(DEV_W, 1'b0);
      tx(c, 1'b0);
      tx(8'hc0, 1'b0);
      tx(8'h00, 1'b0);
      upd(c, 8'hc0, 8'h00);
      tx(8'h00, 1'b1);
      repeat (20) @(posedge clk_i);
      check_all();
      qdac_i2c_master_i.stop();
      hs_m = 1'b0;
      $display("test power-down done");

      // Temp only, load all, broadcast
      for (int k = 0; k < 3; k++) begin
         c = (k == 0) ? 8'h00 : (k == 1) ? 8'h26 : 8'hf2;
         send(c, 8'h3c + 8'(k * 17), 8'h40);
         upd(c, 8'h3c + 8'(k * 17), 8'h40);
         check_all();
      end
      $display("test load modes done");

      // Extension bits must match before a non-broadcast update is kept
      send(8'h52, 8'h11, 8'h80);
      check_all();
      wb(1'b1, qdac_pkg::OFF_CTRL, 32'h3, q);
      rd_chk(qdac_pkg::OFF_CTRL, 32'h3);
      send(8'h52, 8'h11, 8'h80);
      upd(8'h52, 8'h11, 8'h80);
      check_all();
      wb(1'b1, qdac_pkg::OFF_CTRL, 32'h0, q);
      qdac_i2c_master_i.start();
      tx(DEV_W, 1'b1);
      qdac_i2c_master_i.stop();
      $display("test extension and enable done");
      final_report();
   end
endmodule
`default_nettype wire
